// *** common/cipa_defs.svh ***
// Constants for the CPU interrupt priority acceptance block.
// Operation
// - Entry clears enable, loads current priority.
// - No further interrupt until enable or return.
// - Return restores the saved enable state.
// - Block requests not above current priority.
// - Accept requests strictly above current priority.
// - Priority reaches 255; then everything blocked.
// - Vector depends only on pending priority and base.
// - Wide spacing puts eight words between entries.
// - Software writes priority and disables interrupts.
// - Vector is base bit0 cleared OR priority shifted.
// - Pending priority zero never accepted.
// - Entry saves priority and enable; return restores.
`ifndef CIPA_DEFS_SVH
`define CIPA_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define CIPA_OFS_CTRL 4'h0
`define CIPA_OFS_SAVED 4'h4
`define CIPA_OFS_BASE 4'h8
`define CIPA_OFS_STAT 4'hc

// ****************************************************************
// Field positions.
// ****************************************************************
`define CIPA_ENA_BIT 15
`define CIPA_PEND_LSB 16
`define CIPA_SPACE_BIT 0
`define CIPA_WIDE_SHIFT 5
`define CIPA_NARROW_SHIFT 3

// ****************************************************************
// Reset values.
// ****************************************************************
`define CIPA_RST_PRIO 8'h00
`define CIPA_RST_BASE 32'h0000_0000
`define CIPA_MAX_PRIO 8'hff

`endif

// *** common/cipa_pkg.sv ***
// Types shared by the interrupt priority acceptance block.
package cipa_pkg;
  // Priority number carried by requests and by the CPU.
  typedef logic [7:0] cipa_prio_t;
  // Acceptance sequencer states.
  typedef enum logic [1:0] {
    CIPA_IDLE = 2'b00,
    CIPA_ENTRY = 2'b01,
    CIPA_SERVICE = 2'b10
  } cipa_state_t;
endpackage

// *** core/cipa_vector_calc.sv ***
// Vector-table entry address computation.
`timescale 1ns/10ps
`include "cipa_defs.svh"
module cipa_vector_calc
  import cipa_pkg::*;
(
  input wire logic [31:0] i_base,
  input wire cipa_pkg::cipa_prio_t i_prio,
  output logic [31:0] o_entry
);
  // The entry depends only on the priority and the base.
  always_comb begin
    if (i_base[`CIPA_SPACE_BIT] == 1'b0) begin
      // Wide spacing: 32 bytes, eight words per entry.
      o_entry = {i_base[31:1], 1'b0} |
                {19'h0, i_prio, 5'h00};
    end else begin
      // Narrow spacing: eight bytes per entry.
      o_entry = {i_base[31:1], 1'b0} |
                {21'h0, i_prio, 3'h0};
    end
  end
endmodule

// *** core/cipa_accept.sv ***
// CPU interrupt acceptance: priority compare, entry, return, vectoring.
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "cipa_defs.svh"
module cipa_accept (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Pending priority from the interrupt control unit.
  input wire cipa_pkg::cipa_prio_t i_pending_priority_number,
  // Return-from-exception executed, one-cycle pulse.
  input wire logic i_return_from_exception,
  // CPU cannot take an interrupt this cycle (multi-cycle op etc).
  input wire logic i_cpu_busy,
  // Avalon-MM slave.
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  // Acceptance pulse with its vector and priority.
  output logic o_irq_take,
  output logic [31:0] o_vector_pc,
  output cipa_pkg::cipa_prio_t o_taken_priority,
  // Live state of priority and enable.
  output cipa_pkg::cipa_prio_t o_current_cpu_priority,
  output logic o_global_irq_enable
);
  import cipa_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  cipa_state_t state_ff, nxt_state; // Acceptance sequencer.
  cipa_prio_t ccp_ff, nxt_ccp; // Current CPU priority.
  logic gie_ff, nxt_gie; // Global interrupt enable.
  cipa_prio_t scp_ff, nxt_scp; // Saved CPU priority.
  logic sie_ff, nxt_sie; // Saved interrupt enable.
  logic [31:0] base_ff, nxt_base; // Vector table base, bit 0 spacing.
  logic take_ff, nxt_take; // Acceptance pulse.
  logic [31:0] vec_ff, nxt_vec; // Latched vector address.
  cipa_prio_t tprio_ff, nxt_tprio; // Latched accepted priority.
  logic [31:0] rdata_ff, nxt_rdata; // Read data.
  logic ack_ff, nxt_ack; // Low means waitrequest asserted.
  logic [1:0] resp_ff, nxt_resp; // Avalon response code.
  logic [31:0] entry; // Combinational vector entry.
  logic accept; // Request may be taken now.

  // Merge written bytes into an old word.
  function automatic logic [31:0] merge_be(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Vector computation shared with the bus read of the status word.
  cipa_vector_calc u_vec (
    .i_base(base_ff),
    .i_prio(i_pending_priority_number),
    .o_entry(entry)
  );

  // ****************************************************************
  // Acceptance decision.
  // ****************************************************************
  // A zero pending value means nothing pending; the strict compare also
  // blocks everything at priority 255 since no request can exceed it.
  // The pending number is taken from same-clock logic, so no syncer.
  always_comb begin
    accept = gie_ff && !i_cpu_busy && (state_ff == CIPA_IDLE) &&
             (i_pending_priority_number != 8'h00) &&
             (i_pending_priority_number > ccp_ff);
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Bus writes are serviced in the second cycle; hardware entry and
  // return events win over a simultaneous software write because they
  // reflect instructions that have already retired.
  always_comb begin
    logic [31:0] wr;
    logic bus_first;
    logic bus_commit;
    wr = 32'h0;
    bus_first = 1'b0;
    bus_commit = 1'b0;
    nxt_state = state_ff;
    nxt_ccp = ccp_ff;
    nxt_gie = gie_ff;
    nxt_scp = scp_ff;
    nxt_sie = sie_ff;
    nxt_base = base_ff;
    nxt_take = 1'b0;
    nxt_vec = vec_ff;
    nxt_tprio = tprio_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    nxt_resp = resp_ff;
    // Bus access: one wait cycle, then answer. Read data and the response
    // are latched at the end of the wait cycle; a write lands only on the edge at
    // which the master sees waitrequest low, so a write never takes
    // effect while the bus still reports the transfer as unfinished.
    bus_first = (i_avs_read || i_avs_write) && !ack_ff;
    bus_commit = i_avs_write && ack_ff;
    if (bus_first) begin
      nxt_ack = 1'b1;
      nxt_resp = 2'b00;
      nxt_rdata = 32'h0;
    end
    case (i_avs_address)
      `CIPA_OFS_CTRL: begin
        wr = merge_be({16'h0, gie_ff, 7'h00, ccp_ff}, i_avs_writedata,
                      i_avs_byteenable);
        if (bus_first) begin
          nxt_rdata = {8'h00, i_pending_priority_number, gie_ff, 7'h00,
                       ccp_ff};
        end
        if (bus_commit) begin
          // Software may raise, lower or disable at will.
          nxt_ccp = wr[7:0];
          nxt_gie = wr[`CIPA_ENA_BIT];
        end
      end
      `CIPA_OFS_SAVED: begin
        wr = merge_be({16'h0, sie_ff, 7'h00, scp_ff}, i_avs_writedata,
                      i_avs_byteenable);
        if (bus_first) begin
          nxt_rdata = {16'h0, sie_ff, 7'h00, scp_ff};
        end
        if (bus_commit) begin
          nxt_scp = wr[7:0];
          nxt_sie = wr[`CIPA_ENA_BIT];
        end
      end
      `CIPA_OFS_BASE: begin
        if (bus_first) begin
          nxt_rdata = base_ff;
        end
        if (bus_commit) begin
          nxt_base = merge_be(base_ff, i_avs_writedata, i_avs_byteenable);
        end
      end
      `CIPA_OFS_STAT: begin
        // Read-only: entry the pending request would vector to.
        if (bus_first) begin
          nxt_rdata = entry;
        end
      end
      default: begin
        // Unmapped: slave error, read zero, write dropped.
        if (bus_first) begin
          nxt_resp = 2'b10;
        end
      end
    endcase
    // Sequencer.
    case (state_ff)
      CIPA_IDLE: begin
        if (accept) begin
          nxt_scp = ccp_ff;
          nxt_sie = gie_ff;
          nxt_gie = 1'b0;
          nxt_ccp = i_pending_priority_number;
          nxt_vec = entry;
          nxt_tprio = i_pending_priority_number;
          nxt_take = 1'b1;
          nxt_state = CIPA_ENTRY;
        end
      end
      CIPA_ENTRY: begin
        // One settling cycle while the CPU starts the routine.
        nxt_state = CIPA_SERVICE;
      end
      CIPA_SERVICE: begin
        nxt_state = CIPA_IDLE;
      end
      default: begin
        nxt_state = CIPA_IDLE;
      end
    endcase
    // Return restores priority and enable from the saved copy.
    if (i_return_from_exception && !nxt_take) begin
      nxt_ccp = scp_ff;
      nxt_gie = sie_ff;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= CIPA_IDLE;
      ccp_ff <= `CIPA_RST_PRIO;
      gie_ff <= 1'b0;
      scp_ff <= `CIPA_RST_PRIO;
      sie_ff <= 1'b0;
      base_ff <= `CIPA_RST_BASE;
      take_ff <= 1'b0;
      vec_ff <= 32'h0;
      tprio_ff <= 8'h00;
      rdata_ff <= 32'h0;
      ack_ff <= 1'b0;
      resp_ff <= 2'b00;
    end else begin
      state_ff <= nxt_state;
      ccp_ff <= nxt_ccp;
      gie_ff <= nxt_gie;
      scp_ff <= nxt_scp;
      sie_ff <= nxt_sie;
      base_ff <= nxt_base;
      take_ff <= nxt_take;
      vec_ff <= nxt_vec;
      tprio_ff <= nxt_tprio;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      resp_ff <= nxt_resp;
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    o_avs_readdata = rdata_ff;
    o_avs_waitrequest = !ack_ff;
    o_avs_response = resp_ff;
    o_irq_take = take_ff;
    o_vector_pc = vec_ff;
    o_taken_priority = tprio_ff;
    o_current_cpu_priority = ccp_ff;
    o_global_irq_enable = gie_ff;
  end
endmodule

// *** verification/cipa_accept_properties.sv ***
// Checker for the interrupt acceptance block, bound to its ports.
`timescale 1ns/10ps
module cipa_accept_chk (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire cipa_pkg::cipa_prio_t i_pending_priority_number,
  input wire logic i_return_from_exception,
  input wire logic i_cpu_busy,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_irq_take,
  input wire cipa_pkg::cipa_prio_t o_taken_priority,
  input wire cipa_pkg::cipa_prio_t o_current_cpu_priority,
  input wire logic o_global_irq_enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // A request that must win: bus and return are quiet so nothing overrides.
  sequence s_ready;
    o_global_irq_enable && !i_cpu_busy && !i_avs_read && !i_avs_write &&
    !i_return_from_exception &&
    i_pending_priority_number > o_current_cpu_priority;
  endsequence
  // Entry directly followed by a return, no register write in between.
  sequence s_take_ret;
    (o_irq_take && !i_avs_write) ##1
    (i_return_from_exception && !i_avs_write);
  endsequence
  AST_TAKE_STATE: assert property (
    o_irq_take |-> !o_global_irq_enable &&
    o_current_cpu_priority == o_taken_priority)
    else $error("entry state wrong");
  AST_TAKEN_PRIO: assert property (
    o_irq_take |-> o_taken_priority == $past(i_pending_priority_number) &&
    o_taken_priority != 8'h00) else $error("taken priority wrong");
  AST_ABOVE: assert property (
    o_irq_take |-> $past(i_pending_priority_number) >
    $past(o_current_cpu_priority)) else $error("taken not above current");
  AST_GATED: assert property (
    !o_global_irq_enable |=> !o_irq_take) else $error("taken while off");
  AST_MAX: assert property (
    o_current_cpu_priority == 8'hff |=> !o_irq_take)
    else $error("taken at top priority");
  AST_ACCEPT: assert property (
    s_ready and !o_irq_take && !$past(o_irq_take) &&
    !$past(o_irq_take, 2) && !$past(o_irq_take, 3) |=> o_irq_take)
    else $error("higher request not taken");
  AST_PULSE: assert property (
    o_irq_take |=> !o_irq_take [*2]) else $error("take too soon");
  AST_RESTORE: assert property (
    s_take_ret |=> o_global_irq_enable == $past(o_global_irq_enable, 3) &&
    o_current_cpu_priority == $past(o_current_cpu_priority, 3))
    else $error("return did not restore");
endmodule
bind cipa_accept cipa_accept_chk u_chk (.i_core_clk, .i_rst_n,
  .i_pending_priority_number, .i_return_from_exception, .i_cpu_busy,
  .i_avs_read, .i_avs_write, .o_irq_take, .o_taken_priority,
  .o_current_cpu_priority, .o_global_irq_enable);

// *** verification/cipa_icu_model.sv ***
// Behavioural interrupt control unit that presents one pending priority.
`timescale 1ns/10ps
module cipa_icu_model
  import cipa_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire cipa_pkg::cipa_prio_t i_prio,
  input wire logic i_take,
  output cipa_pkg::cipa_prio_t o_pend
);
  cipa_prio_t pend_ff; // Zero means no request is waiting.
  // A taken request is consumed; software may pend it again later.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_ff <= 8'h00;
    end else if (i_set) begin
      pend_ff <= i_prio;
    end else if (i_take) begin
      pend_ff <= 8'h00;
    end
  end
  assign o_pend = pend_ff;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the interrupt acceptance block.
`timescale 1ns/10ps
module tb_top;
  import cipa_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, ret = 0, set = 0, busy = 0;
  logic take, wreq, ena, got;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, vec, q;
  logic [1:0] resp, qr;
  cipa_prio_t req = 8'h00, pend, tprio, cur;
  cipa_prio_t pl[3] = '{8'h01, 8'h02, 8'hff};
  int miscompares = 0, n_tests = 0, tnum = 0;
  always #5 clk = ~clk;
  cipa_icu_model icu (.i_core_clk(clk), .i_rst_n(rst_n), .i_set(set),
    .i_prio(req), .i_take(take), .o_pend(pend));
  cipa_accept dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_pending_priority_number(pend), .i_return_from_exception(ret),
    .i_cpu_busy(busy), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .o_avs_response(resp), .o_irq_take(take), .o_vector_pc(vec),
    .o_taken_priority(tprio), .o_current_cpu_priority(cur),
    .o_global_irq_enable(ena));
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdat;
    qr = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      give_verdict;
    end
  endtask
  task pnd(input cipa_prio_t p);
    @(posedge clk);
    req <= p;
    set <= 1'b1;
    @(posedge clk);
    set <= 1'b0;
  endtask
  // Watches six edges for a take and checks what it carries.
  task tk(input logic e, input logic [31:0] ev, input cipa_prio_t ep);
    got = 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (take === 1'b1) begin
        got = 1'b1;
        cmp(vec, ev);
        cmp(32'(tprio), 32'(ep));
      end
    end
    cmp(32'(got), 32'(e));
    @(negedge clk);
    tnum++;
    $display("test %0d done", tnum);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    cmp(q, 32'h0);
    bus(1'b1, 4'h8, 32'h1000);
    bus(1'b1, 4'h0, 32'h8003);
    pnd(8'd7);
    tk(1'b1, 32'h10e0, 8'd7);
    cmp(32'(cur), 32'h7);
    bus(1'b0, 4'h4, 32'h0);
    cmp(q, 32'h8003);
    pnd(8'd7);
    tk(1'b0, 32'h0, 8'd0);
    bus(1'b1, 4'h0, 32'h8007);
    tk(1'b0, 32'h0, 8'd0);
    pnd(8'd8);
    repeat (2) @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(negedge clk);
    cmp(vec, 32'h1100);
    cmp(32'({ena, cur}), 32'h107);
    bus(1'b1, 4'h0, 32'h8002);
    busy <= 1'b1;
    pnd(8'd5);
    tk(1'b0, 32'h0, 8'd0);
    @(posedge clk);
    busy <= 1'b0;
    tk(1'b1, 32'h10a0, 8'd5);
    bus(1'b1, 4'h0, 32'h80ff);
    pnd(8'd255);
    tk(1'b0, 32'h0, 8'd0);
    pnd(8'd0);
    bus(1'b1, 4'h0, 32'h8000);
    tk(1'b0, 32'h0, 8'd0);
    bus(1'b1, 4'h4, 32'h0009);
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(negedge clk);
    cmp(32'({ena, cur}), 32'h009);
    bus(1'b1, 4'h0, 32'h0);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 4'h8, 32'h1000 | 32'(s));
      foreach (pl[i]) begin
        pnd(pl[i]);
        bus(1'b0, 4'hc, 32'h0);
        cmp(q, 32'h1000 | (32'(pl[i]) << (s ? 3 : 5)));
      end
    end
    bus(1'b0, 4'h2, 32'h0);
    cmp(32'(qr), 32'h2);
    cmp(q, 32'h0);
    give_verdict;
  end
endmodule
